// file: pkg/cbic_pkg.sv
// Constants, request carrier and address compare for the I/O window, IRQ and bridge control slice.
// Assumes one clock shared with the configuration master and byte-addressed, dword-aligned requests.
package cbic_pkg;
  localparam logic [7:0] OFF_IO_TOP0 = 8'h30;
  localparam logic [7:0] OFF_IO_TOP1 = 8'h38;
  localparam logic [7:0] OFF_IRQ_NUM = 8'h3C;
  localparam logic [7:0] OFF_IRQ_CODE = 8'h3D;
  localparam logic [7:0] OFF_BRIDGE = 8'h3E;
  localparam int LIM_LSB = 2;
  localparam int LIM_MSB = 15;
  localparam logic [13:0] LIM_RESET = 14'h0000;
  localparam logic [7:0] IRQ_NUM_RESET = 8'hFF;
  localparam logic [15:0] BRIDGE_RESET = 16'h0340;
  localparam logic [15:0] BRIDGE_WMASK = 16'h07EF;
  localparam int SOCKET_RESET_OUT_BIT = 6;
  localparam int PREF0_BIT = 8;
  localparam int PREF1_BIT = 9;
  localparam logic [7:0] PIN_CODE_A = 8'h01;
  localparam logic [7:0] PIN_CODE_B = 8'h02;
  localparam logic [7:0] PIN_CODE_C = 8'h03;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbic_cfg_req_s;

  // True when the address falls inside base..top; whether the window is enabled is left to the caller.
  function automatic logic cbic_io_hit(input logic [31:0] base, input logic [13:0] lim, input logic [31:0] addr);
    logic [31:0] top;
    top = {base[31:16], lim, 2'b11};
    cbic_io_hit = (addr[31:2] >= base[31:2]) && (addr <= top);
  endfunction : cbic_io_hit
endpackage : cbic_pkg

// file: design/cbic_io_window.sv
// Decodes one I/O window from its base register and its top field.
// Assumes base and address come from logic on the same clock.
`timescale 1ns/1ps
module cbic_io_window (
  input wire logic [31:0] base_in,
  input wire logic [13:0] limit_in,
  input wire logic [31:0] addr_in,
  output logic enabled_out,
  output logic hit_out
);
  import cbic_pkg::*;

  always_comb begin
    enabled_out = (base_in != 32'h0000_0000) || (limit_in != LIM_RESET);
    hit_out = enabled_out && cbic_io_hit(base_in, limit_in, addr_in);
  end
endmodule : cbic_io_window

// file: design/cbic_cfg_regs.sv
// Configuration register slice: I/O window tops, IRQ routing number, IRQ output code, bridge controls.
// Assumes configuration requests on the system clock; IRQ and primary reset arrive as pins.
`timescale 1ns/1ps
module cbic_cfg_regs (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  input wire logic PRIMARY_BUS_RESET_IN,
  input wire cbic_pkg::cbic_cfg_req_s CFG_REQ_IN,
  output logic [31:0] CFG_RDATA_OUT,
  output logic CFG_ACK_OUT,
  input wire logic [1:0] FUNC_NUM_IN,
  input wire logic IO_LIMIT_SEL_IN,
  input wire logic PAIR_IRQ_TIE_IN,
  input wire logic ALL_IRQ_TIE_IN,
  input wire logic [31:0] IO_BASE0_IN,
  input wire logic [31:0] IO_BASE1_IN,
  input wire logic [31:0] IO_ADDR_IN,
  output logic [1:0] IO_HIT_OUT,
  input wire logic [2:0] FUNC_IRQ_IN,
  output logic [2:0] IRQ_OUT,
  output logic SOCKET_RESET_OUT,
  output logic WINDOW0_PREFETCH_FLAG_OUT,
  output logic WINDOW1_PREFETCH_FLAG_OUT,
  output logic [15:0] BRIDGE_CTRL_OUT
);
  import cbic_pkg::*;

  logic primary_bus_reset_meta, primary_bus_reset_sync;
  logic [2:0] irq_meta, irq_sync;
  logic [13:0] lim [2];
  logic [13:0] next_lim [2];
  logic [7:0] irq_num, next_irq_num;
  logic [15:0] bctl, next_bctl;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic [1:0] hit, next_hit;
  logic [2:0] irq_o, next_irq_o;
  logic [1:0] win_hit;
  logic [7:0] pin_code;
  logic [1:0] low_bits;
  logic sel_top0, sel_top1, sel_misc;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      primary_bus_reset_meta <= 1'b0;
      primary_bus_reset_sync <= 1'b0;
      irq_meta <= 3'h0;
      irq_sync <= 3'h0;
    end else if (CE_IN) begin
      primary_bus_reset_meta <= PRIMARY_BUS_RESET_IN;
      primary_bus_reset_sync <= primary_bus_reset_meta;
      irq_meta <= FUNC_IRQ_IN;
      irq_sync <= irq_meta;
    end
  end

  cbic_io_window u_win0 (
    .base_in(IO_BASE0_IN),
    .limit_in(lim[0]),
    .addr_in(IO_ADDR_IN),
    .enabled_out(),
    .hit_out(win_hit[0])
  );

  cbic_io_window u_win1 (
    .base_in(IO_BASE1_IN),
    .limit_in(lim[1]),
    .addr_in(IO_ADDR_IN),
    .enabled_out(),
    .hit_out(win_hit[1])
  );

  always_comb begin
    sel_top0 = CFG_REQ_IN.addr[7:2] == OFF_IO_TOP0[7:2];
    sel_top1 = CFG_REQ_IN.addr[7:2] == OFF_IO_TOP1[7:2];
    sel_misc = CFG_REQ_IN.addr[7:2] == OFF_IRQ_NUM[7:2];
    low_bits = {1'b0, IO_LIMIT_SEL_IN};
    if (ALL_IRQ_TIE_IN) begin
      pin_code = PIN_CODE_A;
    end else if (FUNC_NUM_IN == 2'd1) begin
      pin_code = PAIR_IRQ_TIE_IN ? PIN_CODE_A : PIN_CODE_B;
    end else if (FUNC_NUM_IN == 2'd2) begin
      pin_code = PIN_CODE_C;
    end else begin
      pin_code = PIN_CODE_A;
    end
  end

  always_comb begin
    next_lim = lim;
    next_irq_num = irq_num;
    next_bctl = bctl;
    if (CFG_REQ_IN.wr) begin
      if (sel_top0 || sel_top1) begin
        // Only lanes 0 and 1 carry writable bits; bits 31..16 and 1..0 never load.
        if (CFG_REQ_IN.be[0]) begin
          next_lim[sel_top1][5:0] = CFG_REQ_IN.wdata[7:LIM_LSB];
        end
        if (CFG_REQ_IN.be[1]) begin
          next_lim[sel_top1][13:6] = CFG_REQ_IN.wdata[LIM_MSB:8];
        end
      end
      if (sel_misc && CFG_REQ_IN.be[0]) begin
        next_irq_num = CFG_REQ_IN.wdata[7:0];
      end
      if (sel_misc && CFG_REQ_IN.be[2]) begin
        next_bctl[7:0] = CFG_REQ_IN.wdata[23:16] & BRIDGE_WMASK[7:0];
      end
      if (sel_misc && CFG_REQ_IN.be[3]) begin
        next_bctl[15:8] = CFG_REQ_IN.wdata[31:24] & BRIDGE_WMASK[15:8];
      end
    end
    if (primary_bus_reset_sync) begin
      next_lim[0] = LIM_RESET;
      next_lim[1] = LIM_RESET;
      next_irq_num = IRQ_NUM_RESET;
      next_bctl = BRIDGE_RESET;
      next_bctl[SOCKET_RESET_OUT_BIT] = bctl[SOCKET_RESET_OUT_BIT];
    end
  end

  always_comb begin
    next_ack = CFG_REQ_IN.rd || CFG_REQ_IN.wr;
    next_rdata = 32'h0000_0000;
    if (CFG_REQ_IN.rd) begin
      if (sel_top0) begin
        next_rdata = {16'h0000, lim[0], low_bits};
      end else if (sel_top1) begin
        next_rdata = {16'h0000, lim[1], low_bits};
      end else if (sel_misc) begin
        next_rdata = {bctl, pin_code, irq_num};
      end
    end
    next_hit = win_hit;
    if (ALL_IRQ_TIE_IN) begin
      next_irq_o = {2'b00, |irq_sync};
    end else if (PAIR_IRQ_TIE_IN) begin
      next_irq_o = {irq_sync[2], 1'b0, irq_sync[0] | irq_sync[1]};
    end else begin
      next_irq_o = irq_sync;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      lim[0] <= LIM_RESET;
      lim[1] <= LIM_RESET;
      irq_num <= IRQ_NUM_RESET;
      bctl <= BRIDGE_RESET;
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
      hit <= 2'b00;
      irq_o <= 3'h0;
    end else if (CE_IN) begin
      lim <= next_lim;
      irq_num <= next_irq_num;
      bctl <= next_bctl;
      rdata <= next_rdata;
      ack <= next_ack;
      hit <= next_hit;
      irq_o <= next_irq_o;
    end
  end

  always_comb begin
    CFG_RDATA_OUT = rdata;
    CFG_ACK_OUT = ack && CE_IN;
    IO_HIT_OUT = hit;
    IRQ_OUT = irq_o;
    SOCKET_RESET_OUT = bctl[SOCKET_RESET_OUT_BIT] | primary_bus_reset_sync;
    WINDOW0_PREFETCH_FLAG_OUT = bctl[PREF0_BIT];
    WINDOW1_PREFETCH_FLAG_OUT = bctl[PREF1_BIT];
    BRIDGE_CTRL_OUT = bctl;
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);

  sequence s_read_top0;
    CE_IN && CFG_REQ_IN.rd && sel_top0;
  endsequence

  chk_upper_zero: assert property (s_read_top0 |=> CFG_RDATA_OUT[31:16] == 16'h0000)
    else $error("Upper half of window top read nonzero.");
  chk_low_bits: assert property (s_read_top0 |=> CFG_RDATA_OUT[1:0] == {1'b0, $past(IO_LIMIT_SEL_IN)})
    else $error("Low bits of window top do not follow limit select.");
  chk_limit_store: assert property ((CE_IN && CFG_REQ_IN.wr && sel_top1 && CFG_REQ_IN.be[1:0] == 2'b11 && !primary_bus_reset_sync)
    |=> lim[1] == $past(CFG_REQ_IN.wdata[15:2]))
    else $error("Window top field did not store written value.");
  chk_ro_keep: assert property ((CE_IN && CFG_REQ_IN.wr && sel_misc && CFG_REQ_IN.be[3])
    |=> bctl[15:11] == 5'h00 && !bctl[4])
    else $error("Read-only bridge control bits changed.");
  chk_window_off: assert property ((IO_BASE0_IN == 32'h0000_0000 && lim[0] == LIM_RESET && CE_IN) |=> !IO_HIT_OUT[0])
    else $error("Disabled window produced a hit.");
  chk_pair_tie: assert property ((PAIR_IRQ_TIE_IN && !ALL_IRQ_TIE_IN && FUNC_NUM_IN == 2'd1) |-> pin_code == PIN_CODE_A)
    else $error("Pair tie did not report code 01h.");
  chk_tie_all: assert property ((ALL_IRQ_TIE_IN && CE_IN) |-> pin_code == PIN_CODE_A ##1 IRQ_OUT[2:1] == 2'b00)
    else $error("Tie-all did not merge outputs.");
  chk_line_reset: assert property (@(posedge CLK_SYS_IN) disable iff (1'b0) RESET_IN |=> irq_num == IRQ_NUM_RESET)
    else $error("IRQ routing number did not reset to FFh.");
  chk_bctl_reset: assert property (@(posedge CLK_SYS_IN) disable iff (1'b0) RESET_IN |=> bctl == BRIDGE_RESET)
    else $error("Bridge controls did not reset to 0340h.");
  chk_socket_reset_out_keep: assert property ((CE_IN && primary_bus_reset_sync) |-> SOCKET_RESET_OUT ##1 bctl[SOCKET_RESET_OUT_BIT] == $past(bctl[SOCKET_RESET_OUT_BIT]))
    else $error("Primary reset altered the socket reset bit.");
endmodule : cbic_cfg_regs

// file: sim/cbic_cfg_master.sv
// Configuration master model that issues one-cycle read and write pulses.
// Assumes the block answers with a one-cycle acknowledge on the shared clock.
`timescale 1ns/1ps
module cbic_cfg_master (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] rdata_in,
  output cbic_pkg::cbic_cfg_req_s req_out
);
  import cbic_pkg::*;
  initial req_out = '0;
  // The request carries no function number; the testbench drives FUNC_NUM_IN beside it, with 0 to 2 for IRQ output code reads.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] rdata, output logic ok);
    ok = 1'b0;
    rdata = '0;
    @(negedge clk_in);
    req_out = '{wr: wr, rd: !wr, addr: a, be: be, wdata: d};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_in);
      req_out = '0;
      if (ack_in === 1'b1) begin
        ok = 1'b1;
        rdata = rdata_in;
      end
    end
  endtask : xfer
endmodule : cbic_cfg_master

// file: sim/test_cardbus_bridge_io_limit_irq_cfg.sv
// Testbench for the configuration register slice.
// Assumes one 20 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ps
module test_cardbus_bridge_io_limit_irq_cfg;
  import cbic_pkg::*;
  logic clk = 1'b0, rst = 1'b1, primary_bus_reset = 1'b0, sel = 1'b0, pair = 1'b0, tall = 1'b0, ack, sock, pf0, pf1;
  logic [1:0] fn = 2'h0, hit;
  logic [2:0] irq_in = 3'h0, irq;
  logic [31:0] base0 = 32'h0000_0000, base1 = 32'h0000_0000, addr = 32'h0000_0000, rdata;
  logic [15:0] bctl;
  cbic_cfg_req_s req;
  int n_mismatch = 0, samples_checked = 0;
  always #25 clk = ~clk;
  cbic_cfg_master i_cbic_cfg_master (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .req_out(req));
  cbic_cfg_regs i_cbic_cfg_regs (.CLK_SYS_IN(clk), .RESET_IN(rst), .CE_IN(1'b1), .PRIMARY_BUS_RESET_IN(primary_bus_reset),
    .CFG_REQ_IN(req), .CFG_RDATA_OUT(rdata), .CFG_ACK_OUT(ack), .FUNC_NUM_IN(fn), .IO_LIMIT_SEL_IN(sel),
    .PAIR_IRQ_TIE_IN(pair), .ALL_IRQ_TIE_IN(tall), .IO_BASE0_IN(base0), .IO_BASE1_IN(base1),
    .IO_ADDR_IN(addr), .IO_HIT_OUT(hit), .FUNC_IRQ_IN(irq_in), .IRQ_OUT(irq), .SOCKET_RESET_OUT(sock),
    .WINDOW0_PREFETCH_FLAG_OUT(pf0), .WINDOW1_PREFETCH_FLAG_OUT(pf1), .BRIDGE_CTRL_OUT(bctl));
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] r;
    logic ok;
    i_cbic_cfg_master.xfer(1'b1, a, be, d, r, ok);
  endtask : wr
  // A missing acknowledge turns into a mismatch through the inverted expectation.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic ok;
    i_cbic_cfg_master.xfer(1'b0, a, 4'h0, 32'h0000_0000, r, ok);
    chk(ok ? (r & m) : ~exp, exp);
  endtask : rd
  task automatic io(input logic [31:0] a, input logic [1:0] e);
    @(negedge clk) addr = a;
    @(negedge clk) chk({30'h0000_0000, hit}, {30'h0000_0000, e});
  endtask : io
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'h30, '1, 32'h0000_0000);
    rd(8'h38, '1, 32'h0000_0000);
    rd(8'h3C, '1, 32'h0340_01FF);
    rd(8'h00, '1, 32'h0000_0000);
    chk({29'h0000_0000, sock, pf1, pf0}, 32'h0000_0007);
    wr(8'h30, 4'hF, 32'hFFFF_FFFF);
    rd(8'h30, '1, 32'h0000_FFFC);
    @(negedge clk) sel = 1'b1;
    rd(8'h30, '1, 32'h0000_FFFD);
    wr(8'h38, 4'h1, 32'hFFFF_FFFF);
    rd(8'h38, '1, 32'h0000_00FD);
    wr(8'h3C, 4'hF, 32'hFFFF_FFAA);
    rd(8'h3C, '1, 32'h07EF_01AA);
    wr(8'h3C, 4'hC, 32'h0000_0000);
    rd(8'h3C, '1, 32'h0000_01AA);
    chk({29'h0000_0000, sock, pf1, pf0}, 32'h0000_0000);
    for (int t = 0; t < 3; t++) begin
      for (int f = 0; f < 3; f++) begin
        @(negedge clk);
        pair = (t == 1);
        tall = (t == 2);
        fn = 2'(f);
        rd(8'h3C, 32'h0000_FF00, (t == 2 || (t == 1 && f == 1)) ? 32'h0000_0100 : 32'(f + 1) << 8);
      end
    end
    @(negedge clk) irq_in = 3'h4;
    repeat (5) @(negedge clk);
    chk({29'h0000_0000, irq}, 32'h0000_0001);
    pair = 1'b1;
    tall = 1'b0;
    irq_in = 3'h2;
    repeat (5) @(negedge clk);
    chk({29'h0000_0000, irq}, 32'h0000_0001);
    pair = 1'b0;
    fn = 2'h0;
    repeat (5) @(negedge clk);
    chk({29'h0000_0000, irq}, 32'h0000_0002);
    primary_bus_reset = 1'b1;
    repeat (4) @(negedge clk);
    chk({31'h0000_0000, sock}, 32'h0000_0001);
    primary_bus_reset = 1'b0;
    sel = 1'b0;
    repeat (4) @(negedge clk);
    chk({16'h0000, bctl}, 32'h0000_0300);
    rd(8'h3C, 32'h0000_00FF, 32'h0000_00FF);
    io(32'h0000_0000, 2'b00);
    wr(8'h30, 4'h3, 32'h0000_0100);
    @(negedge clk) base0 = 32'h0000_0040;
    io(32'h0000_0040, 2'b01);
    io(32'h0000_0103, 2'b01);
    io(32'h0000_0104, 2'b00);
    io(32'h0000_003C, 2'b00);
    chk({31'h0000_0000, hit[1]}, 32'h0000_0000);
    wr(8'h38, 4'h3, 32'h0000_0200);
    @(negedge clk) base1 = 32'h0001_0180;
    io(32'h0001_0203, 2'b10);
    io(32'h0000_0100, 2'b01);
    io(32'h0001_0204, 2'b00);
    io(32'h0000_0200, 2'b00);
    close_out();
  end
endmodule : test_cardbus_bridge_io_limit_irq_cfg
